// ==== ljt_pkg.sv ====
package ljt_pkg;
    localparam int CLK_FREQ_MHZ    = 20;
    localparam int PROG_CYCLE_US   = 5000;
    localparam int PROG_CYCLE_CLKS = PROG_CYCLE_US * CLK_FREQ_MHZ;
    localparam int TIME_STEP_MS    = 5;
    localparam int MAX_TIME_MS     = 1800000;
    localparam int MAX_TIME_TICKS  = MAX_TIME_MS / TIME_STEP_MS;
    localparam int TIME_W          = 19;
    localparam int PRETRIG_MS      = 20;
    localparam int PREFAULT_MS     = 200;
    localparam int PRETRIG_TICKS   = PRETRIG_MS / TIME_STEP_MS;
    localparam int PREFAULT_TICKS  = PREFAULT_MS / TIME_STEP_MS;
    localparam int BLOCK_LEAD_MS   = 5;
    localparam int CUR_W           = 16;
    localparam int RATIO_W         = 17;
    localparam logic [22:0] RATIO_SCALE = 23'h000064;
    localparam logic [RATIO_W-1:0] RATIO_MAX = 17'h1E848;
    localparam int RING_DEPTH      = 12;
    localparam int CNT_W           = 16;
    localparam int STAMP_W         = 32;
    localparam int REC_W = STAMP_W + 3 + 3 + 3 * CUR_W + TIME_W + 3;
    localparam logic [2:0] EV_START_ON  = 3'h0;
    localparam logic [2:0] EV_START_OFF = 3'h1;
    localparam logic [2:0] EV_TRIP_ON   = 3'h2;
    localparam logic [2:0] EV_TRIP_OFF  = 3'h3;
    localparam logic [2:0] EV_BLOCK_ON  = 3'h4;
    localparam logic [2:0] EV_BLOCK_OFF = 3'h5;
    typedef enum logic [1:0] {
        ST_NORMAL  = 2'h0,
        ST_START   = 2'h1,
        ST_TRIP    = 2'h3,
        ST_BLOCKED = 2'h2
    } ljt_state_type;
endpackage : ljt_pkg

// ==== ljt_load_jam_stage.sv ====
`timescale 1ns/100ps
// Operation
// - definite-time operate and release delays only
// - condition is normal, started, tripped or blocked
// - expected operating time shown in 5 ms steps
// - signed time left to trip while counting
// - highest current over pickup setting, hundredths
// - blocking sampled at start of each cycle
// - pickup without blocking starts operate timing
// - pickup with blocking gives blocked, no timing
// - late blocking drops start, runs release timing
// - on and off events for start, trip, block
// - per-event mask chooses stored events
// - every event carries its time stamp
// - counters for starts, trips and blocks
// - ring of twelve records on on-transitions
// - record holds stamp, currents, time, group
module ljt_load_jam_stage
    import ljt_pkg::*;
#(
    parameter int PROG_CLKS = PROG_CYCLE_CLKS
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  pickup_in,
    input  wire logic                  block_in,
    input  wire logic [CUR_W-1:0]      highest_phase_current,
    input  wire logic [CUR_W-1:0]      pickup_current_setting,
    input  wire logic [2:0]            fault_phases,
    input  wire logic [2:0]            setting_group,
    input  wire logic [STAMP_W-1:0]    time_stamp,
    input  wire logic [TIME_W-1:0]     operate_delay,
    input  wire logic [TIME_W-1:0]     release_delay,
    input  wire logic [5:0]            event_mask,
    input  wire logic [3:0]            rec_sel,
    output logic                       start_out,
    output logic                       trip_out,
    output logic                       blocked_out,
    output ljt_state_type              condition,
    output logic [TIME_W-1:0]          expected_time,
    output logic signed [TIME_W:0]     remaining_time,
    output logic [RATIO_W-1:0]         current_ratio,
    output logic                       event_valid,
    output logic [2:0]                 event_code,
    output logic [STAMP_W-1:0]         event_stamp,
    output logic [CNT_W-1:0]           start_count,
    output logic [CNT_W-1:0]           trip_count,
    output logic [CNT_W-1:0]           block_count,
    output logic [3:0]                 rec_count,
    output logic [3:0]                 rec_write_ptr,
    output logic [REC_W-1:0]           rec_data
);
    localparam int DIV_W = $clog2(PROG_CLKS);
    localparam logic [DIV_W-1:0] DIV_TOP = DIV_W'(PROG_CLKS - 1);

    typedef struct packed {
        logic [DIV_W-1:0]                div;
        logic                            tick_d;
        logic                            blk;
        ljt_state_type                   st;
        logic                            start_q;
        logic                            trip_q;
        logic                            blocked_q;
        logic [TIME_W-1:0]               elapsed;
        logic [TIME_W-1:0]               rel;
        logic                            rel_run;
        logic [TIME_W-1:0]               expct;
        logic signed [TIME_W:0]          remain;
        logic [RATIO_W-1:0]              ratio;
        logic [5:0]                      pend;
        logic [STAMP_W-1:0]              pstamp;
        logic                            ev_valid;
        logic [2:0]                      ev_code;
        logic [STAMP_W-1:0]              ev_stamp;
        logic [CNT_W-1:0]                cnt_start;
        logic [CNT_W-1:0]                cnt_trip;
        logic [CNT_W-1:0]                cnt_block;
        logic [PREFAULT_TICKS-1:0][CUR_W-1:0] hist;
        logic [RING_DEPTH-1:0][REC_W-1:0] ring;
        logic [3:0]                      wptr;
        logic [3:0]                      rcount;
        logic [REC_W-1:0]                rdata;
    } ljt_regs_type;

    ljt_regs_type r_reg;
    ljt_regs_type r_next;
    logic         tick;

    assign tick = (r_reg.div == '0);

    always_comb begin
        logic [22:0]       quot;
        logic [5:0]        chg;
        logic [2:0]        rec_ev;
        logic              rec_wr;
        logic [TIME_W-1:0] left;
        quot   = '0;
        chg    = '0;
        rec_ev = EV_START_ON;
        rec_wr = 1'b0;
        left   = '0;
        r_next = r_reg;
        r_next.ev_valid = 1'b0;
        r_next.div = tick ? DIV_TOP : r_reg.div - 1'b1;
        r_next.tick_d = tick;
        // latch blocking first, pickup is judged one clock later
        if (tick) begin
            r_next.blk = block_in;
        end
        // drain one pending event per clock; a new set below wins
        for (int i = 5; i >= 0; i--) begin
            if (r_reg.pend[i]) begin
                r_next.ev_valid = 1'b1;
                r_next.ev_code  = 3'(i);
                r_next.ev_stamp = r_reg.pstamp;
            end
        end
        if (r_next.ev_valid) begin
            r_next.pend[r_next.ev_code] = 1'b0;
        end
        if (r_reg.tick_d) begin
            r_next.expct = operate_delay;
            case (r_reg.st)
                ST_NORMAL: begin
                    if (pickup_in && r_reg.blk) begin
                        r_next.st = ST_BLOCKED;
                    end else if (pickup_in) begin
                        r_next.st = ST_START;
                        r_next.rel_run = 1'b0;
                        if (!r_reg.rel_run) begin
                            r_next.elapsed = '0;
                        end
                    end else if (r_reg.rel_run) begin
                        r_next.rel = r_reg.rel + 1'b1;
                        if (r_next.rel >= release_delay) begin
                            r_next.rel_run = 1'b0;
                            r_next.elapsed = '0;
                        end
                    end
                end
                ST_START: begin
                    if (r_reg.blk || !pickup_in) begin
                        r_next.st = ST_NORMAL;
                        r_next.rel_run = 1'b1;
                        r_next.rel = '0;
                    end else begin
                        r_next.elapsed = r_reg.elapsed + 1'b1;
                        if (r_next.elapsed >= operate_delay) begin
                            r_next.st = ST_TRIP;
                        end
                    end
                end
                ST_TRIP: begin
                    if (!pickup_in || r_reg.blk) begin
                        r_next.st = ST_NORMAL;
                        r_next.elapsed = '0;
                    end
                end
                ST_BLOCKED: begin
                    if (!pickup_in) begin
                        r_next.st = ST_NORMAL;
                    end else if (!r_reg.blk) begin
                        r_next.st = ST_START;
                        r_next.elapsed = '0;
                    end
                end
                default: r_next.st = ST_NORMAL;
            endcase
            r_next.start_q   = (r_next.st == ST_START);
            r_next.trip_q    = (r_next.st == ST_TRIP);
            r_next.blocked_q = (r_next.st == ST_BLOCKED);
            if (r_next.start_q) begin
                left = operate_delay - r_next.elapsed;
                r_next.remain = $signed({1'b0, operate_delay})
                              - $signed({1'b0, r_next.elapsed});
            end else begin
                r_next.remain = '0;
            end
            if (pickup_current_setting == '0) begin
                r_next.ratio = RATIO_MAX;
            end else begin
                quot = (23'(highest_phase_current) * RATIO_SCALE)
                     / 23'(pickup_current_setting);
                r_next.ratio = (quot > 23'(RATIO_MAX)) ? RATIO_MAX
                             : quot[RATIO_W-1:0];
            end
            chg[EV_START_ON]  = r_next.start_q && !r_reg.start_q;
            chg[EV_START_OFF] = !r_next.start_q && r_reg.start_q;
            chg[EV_TRIP_ON]   = r_next.trip_q && !r_reg.trip_q;
            chg[EV_TRIP_OFF]  = !r_next.trip_q && r_reg.trip_q;
            chg[EV_BLOCK_ON]  = r_next.blocked_q && !r_reg.blocked_q;
            chg[EV_BLOCK_OFF] = !r_next.blocked_q && r_reg.blocked_q;
            if ((chg & event_mask) != '0) begin
                r_next.pstamp = time_stamp;
            end
            r_next.pend = r_next.pend
                        | (chg & event_mask);
            if (chg[EV_START_ON]) begin
                r_next.cnt_start = r_reg.cnt_start + 1'b1;
            end
            if (chg[EV_TRIP_ON]) begin
                r_next.cnt_trip = r_reg.cnt_trip + 1'b1;
            end
            if (chg[EV_BLOCK_ON]) begin
                r_next.cnt_block = r_reg.cnt_block + 1'b1;
            end
            // one record per cycle: trip outranks start outranks block
            if (chg[EV_TRIP_ON]) begin
                rec_wr = 1'b1;
                rec_ev = EV_TRIP_ON;
            end else if (chg[EV_START_ON]) begin
                rec_wr = 1'b1;
                rec_ev = EV_START_ON;
            end else if (chg[EV_BLOCK_ON]) begin
                rec_wr = 1'b1;
                rec_ev = EV_BLOCK_ON;
            end
            if (rec_wr) begin
                r_next.ring[r_reg.wptr] = {time_stamp, rec_ev, fault_phases,
                    r_reg.hist[PRETRIG_TICKS-1], highest_phase_current,
                    r_reg.hist[PREFAULT_TICKS-1], left,
                    setting_group};
                r_next.wptr = (r_reg.wptr == 4'(RING_DEPTH - 1)) ? 4'h0
                            : r_reg.wptr + 1'b1;
                if (r_reg.rcount != 4'(RING_DEPTH)) begin
                    r_next.rcount = r_reg.rcount + 1'b1;
                end
            end
            r_next.hist = {r_reg.hist[PREFAULT_TICKS-2:0],
                           highest_phase_current};
        end
        r_next.rdata = (rec_sel < 4'(RING_DEPTH)) ? r_reg.ring[rec_sel]
                                                  : '0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign start_out      = r_reg.start_q;
    assign trip_out       = r_reg.trip_q;
    assign blocked_out    = r_reg.blocked_q;
    assign condition      = r_reg.st;
    assign expected_time  = r_reg.expct;
    assign remaining_time = r_reg.remain;
    assign current_ratio  = r_reg.ratio;
    assign event_valid    = r_reg.ev_valid;
    assign event_code     = r_reg.ev_code;
    assign event_stamp    = r_reg.ev_stamp;
    assign start_count    = r_reg.cnt_start;
    assign trip_count     = r_reg.cnt_trip;
    assign block_count    = r_reg.cnt_block;
    assign rec_count      = r_reg.rcount;
    assign rec_write_ptr  = r_reg.wptr;
    assign rec_data       = r_reg.rdata;

    state_onehot_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (32'(r_reg.start_q) + 32'(r_reg.trip_q) + 32'(r_reg.blocked_q)) <= 1
        && (r_reg.start_q == (r_reg.st == ST_START)))
        else $error("condition flags disagree");
    block_sample_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        tick |=> r_reg.tick_d && (r_reg.blk == $past(block_in)))
        else $error("blocking not latched at cycle start");
    start_entry_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.tick_d && r_reg.st == ST_NORMAL && pickup_in && !r_reg.blk
        |=> r_reg.start_q || r_reg.trip_q)
        else $error("pickup did not start");
    blocked_entry_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.tick_d && r_reg.st == ST_NORMAL && pickup_in && r_reg.blk
        |=> r_reg.blocked_q && !r_reg.start_q)
        else $error("blocked pickup not reported");
    late_block_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.tick_d && r_reg.start_q && r_reg.blk
        |=> !r_reg.start_q && r_reg.rel_run && r_reg.rel == '0)
        else $error("late blocking kept start");
    trip_delay_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.tick_d && r_reg.start_q && pickup_in && !r_reg.blk
        && (r_reg.elapsed + 1'b1 >= operate_delay) |=> r_reg.trip_q)
        else $error("trip missing after delay");
    remain_val_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.start_q |-> r_reg.remain == $signed({1'b0, r_reg.expct})
        - $signed({1'b0, r_reg.elapsed}))
        else $error("remaining time wrong");
    start_count_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(r_reg.start_q) |-> r_reg.cnt_start
        == CNT_W'($past(r_reg.cnt_start) + 1'b1))
        else $error("start counter did not step");
    event_emit_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.pend != '0 |=> r_reg.ev_valid)
        else $error("pending event not issued");
    ring_write_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(r_reg.trip_q) |-> r_reg.wptr != $past(r_reg.wptr))
        else $error("trip record not written");
    trip_count_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        $rose(r_reg.trip_q) |-> r_reg.cnt_trip
        == CNT_W'($past(r_reg.cnt_trip) + 1'b1))
        else $error("trip counter did not step");
    ring_bound_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        r_reg.rcount <= 4'(RING_DEPTH) && r_reg.wptr < 4'(RING_DEPTH))
        else $error("record ring index out of range");

endmodule : ljt_load_jam_stage

// ==== ljt_matrix_buffer.sv ====
`timescale 1ns/100ps
module ljt_matrix_buffer
    import ljt_pkg::*;
(
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               block_req,
    output logic                    block_in,
    input  wire logic               event_valid,
    input  wire logic [2:0]         event_code,
    input  wire logic [STAMP_W-1:0] event_stamp,
    output logic [7:0]              ev_count,
    output logic [2:0]              last_code,
    output logic [STAMP_W-1:0]      last_stamp
);
    // matrix output lags the request by one clock; the bench raises it
    // whole program cycles ahead of any operate delay expiry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            block_in   <= 1'b0;
            ev_count   <= 8'h00;
            last_code  <= 3'h7;
            last_stamp <= 32'h00000000;
        end else begin
            block_in <= block_req;
            if (event_valid) begin
                ev_count   <= ev_count + 8'h01;
                last_code  <= event_code;
                last_stamp <= event_stamp;
            end
        end
    end
endmodule : ljt_matrix_buffer

// ==== ljt_load_jam_trip_supervisor_bench.sv ====
`timescale 1ns/100ps
module ljt_load_jam_trip_supervisor_bench
    import ljt_pkg::*;
;
    logic                clk_sys, rst, pickup_in, block_req, block_in;
    logic [CUR_W-1:0]    highest_phase_current, pickup_current_setting;
    logic [2:0]          fault_phases, setting_group, event_code, last_code;
    logic [STAMP_W-1:0]  time_stamp, event_stamp, last_stamp;
    logic [TIME_W-1:0]   operate_delay, release_delay, expected_time;
    logic [5:0]          event_mask;
    logic [3:0]          rec_sel, rec_count, rec_write_ptr;
    logic                start_out, trip_out, blocked_out, event_valid;
    ljt_state_type       condition;
    logic signed [TIME_W:0] remaining_time;
    logic [RATIO_W-1:0]  current_ratio;
    logic [CNT_W-1:0]    start_count, trip_count, block_count;
    logic [REC_W-1:0]    rec_data;
    logic [7:0]          ev_count, n0;
    int                  mismatches, checked;
    logic [2:0]          flags;

    assign flags = {blocked_out, trip_out, start_out};

    ljt_load_jam_stage #(.PROG_CLKS(8)) DUT (.clk_sys, .rst, .pickup_in,
        .block_in, .highest_phase_current, .pickup_current_setting,
        .fault_phases, .setting_group, .time_stamp, .operate_delay,
        .release_delay, .event_mask, .rec_sel, .start_out, .trip_out,
        .blocked_out, .condition, .expected_time, .remaining_time,
        .current_ratio, .event_valid, .event_code, .event_stamp,
        .start_count, .trip_count, .block_count, .rec_count,
        .rec_write_ptr, .rec_data);
    ljt_matrix_buffer partner (.clk_sys, .rst, .block_req, .block_in,
        .event_valid, .event_code, .event_stamp, .ev_count, .last_code,
        .last_stamp);

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic set_in(logic p, logic b);
        @(posedge clk_sys);
        pickup_in  <= p;
        block_req  <= b;
        time_stamp <= time_stamp + 32'h00010000;
    endtask : set_in

    // bounded so a stuck flag reports instead of hanging the run
    // idx 0 start, 1 trip, 2 blocked
    task automatic wait_on(input int idx, input logic lvl);
        for (int k = 0; k < 80 && flags[idx] !== lvl; k++) begin
            @(negedge clk_sys);
        end
    endtask : wait_on

    task automatic t_start_trip;
        int n;
        set_in(1'b1, 1'b0);
        wait_on(0, 1'b1);
        check("cond", condition, ST_START);
        check("starts", start_count, 16'h0001);
        check("exp_time", expected_time, operate_delay);
        check("remain", remaining_time, operate_delay);
        check("ratio", current_ratio, 17'h00258);
        check("recs", rec_count, 4'h1);
        for (n = 0; n < 100 && trip_out !== 1'b1; n++) @(negedge clk_sys);
        check("trip_clks", n, 24);
        check("cond", condition, ST_TRIP);
        check("trips", trip_count, 16'h0001);
        check("remain0", remaining_time, 64'h0);
        repeat (3) @(negedge clk_sys);
        check("code", last_code, EV_TRIP_ON);
        check("stamp", last_stamp, time_stamp);
        check("r_stamp", rec_data[107:76], time_stamp);
        check("r_event", rec_data[75:73], EV_START_ON);
        check("r_phase", rec_data[72:70], fault_phases);
        check("r_cur", rec_data[53:38], highest_phase_current);
        check("r_group", rec_data[2:0], setting_group);
        check("r_left", rec_data[21:3], operate_delay);
        $display("test start_trip done");
    endtask : t_start_trip

    task automatic t_release;
        set_in(1'b0, 1'b0);
        wait_on(1, 1'b0);
        check("start", start_out, 1'b0);
        check("cond", condition, ST_NORMAL);
        repeat (4) @(negedge clk_sys);
        check("events", ev_count, 8'h04);
        check("code", last_code, EV_TRIP_OFF);
        $display("test release done");
    endtask : t_release

    task automatic t_blocked;
        set_in(1'b0, 1'b1);
        repeat (16) @(negedge clk_sys);
        set_in(1'b1, 1'b1);
        wait_on(2, 1'b1);
        check("cond", condition, ST_BLOCKED);
        check("blocks", block_count, 16'h0001);
        repeat (40) @(negedge clk_sys);
        check("trip", trip_out, 1'b0);
        check("starts", start_count, 16'h0001);
        check("code", last_code, EV_BLOCK_ON);
        set_in(1'b0, 1'b0);
        wait_on(2, 1'b0);
        repeat (4) @(negedge clk_sys);
        check("code", last_code, EV_BLOCK_OFF);
        check("events", ev_count, 8'h06);
        $display("test blocked done");
    endtask : t_blocked

    task automatic t_late_block;
        set_in(1'b1, 1'b0);
        wait_on(0, 1'b1);
        set_in(1'b1, 1'b1);
        wait_on(0, 1'b0);
        check("start", start_out, 1'b0);
        repeat (40) @(negedge clk_sys);
        check("trip", trip_out, 1'b0);
        set_in(1'b0, 1'b0);
        repeat (24) @(negedge clk_sys);
        $display("test late_block done");
    endtask : t_late_block

    task automatic t_mask;
        @(posedge clk_sys);
        event_mask <= 6'h3E;
        n0 = ev_count;
        set_in(1'b1, 1'b0);
        wait_on(0, 1'b1);
        repeat (3) @(negedge clk_sys);
        check("masked", ev_count, n0);
        set_in(1'b0, 1'b0);
        wait_on(0, 1'b0);
        repeat (3) @(negedge clk_sys);
        check("kept", ev_count, n0 + 8'h01);
        check("code", last_code, EV_START_OFF);
        @(posedge clk_sys);
        event_mask <= 6'h3F;
        $display("test mask done");
    endtask : t_mask

    task automatic t_ring;
        repeat (12) begin
            set_in(1'b1, 1'b0);
            wait_on(0, 1'b1);
            set_in(1'b0, 1'b0);
            wait_on(0, 1'b0);
        end
        check("recs", rec_count, 4'hC);
        check("wptr", rec_write_ptr, 4'h6);
        check("starts", start_count, 16'h000F);
        // 18 records so far: the newest one sits in slot 5
        @(posedge clk_sys);
        rec_sel <= 4'h5;
        highest_phase_current <= 16'h0FFF;
        pickup_current_setting <= 16'h0001;
        repeat (10) @(negedge clk_sys);
        check("r_event", rec_data[75:73], EV_START_ON);
        check("r_pre", rec_data[69:54], 16'h0258);
        check("r_prefault", rec_data[37:22], 16'h0258);
        check("ratio_sat", current_ratio, RATIO_MAX);
        $display("test ring done");
    endtask : t_ring

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    initial begin
        #400000;
        mismatches++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        pickup_in = 1'b0;
        block_req = 1'b0;
        highest_phase_current = 16'h0258;
        pickup_current_setting = 16'h0064;
        fault_phases = 3'h5;
        setting_group = 3'h2;
        time_stamp = 32'h00001234;
        operate_delay = 19'h00003;
        release_delay = 19'h00000;
        event_mask = 6'h3F;
        rec_sel = 4'h0;
        mismatches = 0;
        checked = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check("cond", condition, ST_NORMAL);
        check("flags", {start_out, trip_out, blocked_out}, 3'h0);
        t_start_trip();
        t_release();
        t_blocked();
        t_late_block();
        t_mask();
        t_ring();
        final_report();
    end
endmodule : ljt_load_jam_trip_supervisor_bench
